/* hdl/cspm_pkg.sv */
package cspm_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [9:0] IDX_PLL_CONTROL      = 10'h010;
  localparam logic [9:0] IDX_VCO_CAL_CONTROL  = 10'h018;
  localparam logic [9:0] IDX_PRESCALE_DIV_SEL = 10'h1e0;
  localparam logic [9:0] IDX_INPUT_ROUTING    = 10'h1e1;
  localparam logic [9:0] IDX_UPDATE_STROBE    = 10'h232;
  localparam logic [9:0] IDX_PATH_STATUS      = 10'h233;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PLL_MODE_LSB    = 0;
  localparam int PFD_POL_BIT     = 7;
  localparam int CAL_BIT         = 0;
  localparam int DIV_SEL_LSB     = 0;
  localparam int ROUTE_BYPASS_BIT = 0;
  localparam int ROUTE_SRC_BIT   = 1;
  localparam int UPDATE_BIT      = 0;

  // ----------------------------------------------------------------
  // Encodings and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] PLL_MODE_NORMAL = 2'h0;
  localparam logic [1:0] PLL_MODE_PWRDN  = 2'h1;

  localparam logic [7:0] RST_PLL_CONTROL = 8'h01;
  localparam logic [7:0] RST_VCO_CAL     = 8'h00;
  localparam logic [7:0] RST_DIV_SEL     = 8'h02;
  localparam logic [7:0] RST_ROUTING     = 8'h00;

  localparam logic [2:0] DIV_RATIO_MIN   = 3'h2;
  localparam logic [2:0] DIV_RATIO_MAX   = 3'h6;
  localparam logic [2:0] DIV_CODE_MAX    = 3'h4;

endpackage : cspm_pkg

/* hdl/cspm_div_decode.sv */
`timescale 1ns/1ns
module cspm_div_decode (
  input  wire logic [2:0] div_code,
  output logic      [2:0] div_ratio
);

  // ----------------------------------------------------------------
  // Select code to ratio, unlisted codes held at the top ratio
  // ----------------------------------------------------------------
  always_comb begin
    if (div_code > cspm_pkg::DIV_CODE_MAX) begin
      div_ratio = cspm_pkg::DIV_RATIO_MAX;
    end else begin
      div_ratio = 3'(div_code + cspm_pkg::DIV_RATIO_MIN);
    end
  end

endmodule : cspm_div_decode

/* hdl/cspm_clock_path_cfg.sv */
`timescale 1ns/1ns
//
// Contract
// - After reset the PLL is off (mode 01b), divider code is 010b (divide by four), divider in path, external clock chosen.
// - A PLL mode field of 01b places the PLL in asynchronous power-down.
// - A PLL mode field of 00b runs the PLL in normal operation.
// - The divider select field programs division by 2 to 6, never below two while the divider is in the path.
// - Routing bit 0 clear feeds distribution from the divider, set feeds the undivided source.
// - Routing bit 1 clear picks the external clock input, set picks the internal VCO.
// - PLL control bit 7 sets PFD polarity, 0 positive and 1 negative.
// - With the PLL on and the external source, the internal VCO stays off and the external clock goes to the prescaler.
//
module cspm_clock_path_cfg (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             pll_pwrdn,
  output logic             pll_run,
  output logic             pfd_negative,
  output logic             vco_pwr_en,
  output logic             ext_to_prescaler,
  output logic      [2:0]  div_ratio,
  output logic             div_bypass,
  output logic             src_vco,
  output logic             cal_reset,
  output logic             cal_start
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [11:0] addr, input logic [9:0] idx);
    hit = (addr[1:0] == 2'h0) && (addr[11:2] == idx);
  endfunction : hit

  function automatic logic mapped(input logic [11:0] addr);
    mapped = hit(addr, cspm_pkg::IDX_PLL_CONTROL) || hit(addr, cspm_pkg::IDX_VCO_CAL_CONTROL) ||
             hit(addr, cspm_pkg::IDX_PRESCALE_DIV_SEL) || hit(addr, cspm_pkg::IDX_INPUT_ROUTING) ||
             hit(addr, cspm_pkg::IDX_UPDATE_STROBE) || hit(addr, cspm_pkg::IDX_PATH_STATUS);
  endfunction : mapped

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]  pll_ctl_q,  pll_ctl_d;
  logic [7:0]  cal_ctl_q,  cal_ctl_d;
  logic [7:0]  div_sel_q,  div_sel_d;
  logic [7:0]  route_q,    route_d;
  logic [31:0] prdata_q,   prdata_d;
  logic        pready_q,   pready_d;
  logic        pslverr_q,  pslverr_d;
  logic        act_cal_q,  act_cal_d;
  logic        pll_pwrdn_q, pll_pwrdn_d;
  logic        pll_run_q,   pll_run_d;
  logic        pfd_neg_q,   pfd_neg_d;
  logic        vco_pwr_q,   vco_pwr_d;
  logic        ext_pre_q,   ext_pre_d;
  logic [2:0]  div_ratio_q, div_ratio_d;
  logic        bypass_q,    bypass_d;
  logic        src_vco_q,   src_vco_d;
  logic        cal_reset_q, cal_reset_d;
  logic        cal_start_q, cal_start_d;
  logic        wr_en;
  logic        upd_fire;
  logic [2:0]  staged_ratio;
  logic [31:0] status_word;

  cspm_div_decode u_div_decode (
    .div_code  (div_sel_q[cspm_pkg::DIV_SEL_LSB +: 3]),
    .div_ratio (staged_ratio)
  );

  assign wr_en    = psel && penable && pready_q && pwrite && pstrb[0] && !pslverr_q;
  assign upd_fire = wr_en && hit(paddr, cspm_pkg::IDX_UPDATE_STROBE) &&
                    pwdata[cspm_pkg::UPDATE_BIT];

  always_comb begin
    status_word      = 32'h0;
    status_word[0]   = pll_run_q;
    status_word[1]   = pll_pwrdn_q;
    status_word[2]   = vco_pwr_q;
    status_word[3]   = bypass_q;
    status_word[4]   = src_vco_q;
    status_word[5]   = act_cal_q;
    status_word[8 +: 3] = div_ratio_q;
  end

  // ----------------------------------------------------------------
  // APB slave: answer prepared in setup, one access cycle
  // ----------------------------------------------------------------
  always_comb begin
    prdata_d  = 32'h0;
    pslverr_d = 1'b0;
    pready_d  = 1'b0;
    if (psel && !penable) begin
      pready_d  = 1'b1;
      pslverr_d = !mapped(paddr);
      if (!pwrite) begin
        if (hit(paddr, cspm_pkg::IDX_PLL_CONTROL)) begin
          prdata_d[7:0] = pll_ctl_q;
        end else if (hit(paddr, cspm_pkg::IDX_VCO_CAL_CONTROL)) begin
          prdata_d[7:0] = cal_ctl_q;
        end else if (hit(paddr, cspm_pkg::IDX_PRESCALE_DIV_SEL)) begin
          prdata_d[7:0] = div_sel_q;
        end else if (hit(paddr, cspm_pkg::IDX_INPUT_ROUTING)) begin
          prdata_d[7:0] = route_q;
        end else if (hit(paddr, cspm_pkg::IDX_PATH_STATUS)) begin
          prdata_d = status_word;
        end else begin
          prdata_d = 32'h0;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      prdata_q  <= 32'h0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // ----------------------------------------------------------------
  // Staged registers
  // ----------------------------------------------------------------
  always_comb begin
    pll_ctl_d = pll_ctl_q;
    cal_ctl_d = cal_ctl_q;
    div_sel_d = div_sel_q;
    route_d   = route_q;
    if (wr_en) begin
      if (hit(paddr, cspm_pkg::IDX_PLL_CONTROL)) begin
        pll_ctl_d = pwdata[7:0];
      end
      if (hit(paddr, cspm_pkg::IDX_VCO_CAL_CONTROL)) begin
        cal_ctl_d = pwdata[7:0];
      end
      if (hit(paddr, cspm_pkg::IDX_PRESCALE_DIV_SEL)) begin
        div_sel_d = pwdata[7:0];
      end
      if (hit(paddr, cspm_pkg::IDX_INPUT_ROUTING)) begin
        route_d = pwdata[7:0];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pll_ctl_q <= cspm_pkg::RST_PLL_CONTROL;
      cal_ctl_q <= cspm_pkg::RST_VCO_CAL;
      div_sel_q <= cspm_pkg::RST_DIV_SEL;
      route_q   <= cspm_pkg::RST_ROUTING;
    end else begin
      pll_ctl_q <= pll_ctl_d;
      cal_ctl_q <= cal_ctl_d;
      div_sel_q <= div_sel_d;
      route_q   <= route_d;
    end
  end

  // ----------------------------------------------------------------
  // Active configuration, loaded in one step on update
  // ----------------------------------------------------------------
  always_comb begin
    act_cal_d   = act_cal_q;
    pll_pwrdn_d = pll_pwrdn_q;
    pll_run_d   = pll_run_q;
    pfd_neg_d   = pfd_neg_q;
    div_ratio_d = div_ratio_q;
    bypass_d    = bypass_q;
    src_vco_d   = src_vco_q;
    cal_reset_d = 1'b0;
    cal_start_d = 1'b0;
    if (upd_fire) begin
      act_cal_d   = cal_ctl_q[cspm_pkg::CAL_BIT];
      pll_pwrdn_d = pll_ctl_q[cspm_pkg::PLL_MODE_LSB +: 2] == cspm_pkg::PLL_MODE_PWRDN;
      pll_run_d   = pll_ctl_q[cspm_pkg::PLL_MODE_LSB +: 2] == cspm_pkg::PLL_MODE_NORMAL;
      pfd_neg_d   = pll_ctl_q[cspm_pkg::PFD_POL_BIT];
      div_ratio_d = staged_ratio;
      bypass_d    = route_q[cspm_pkg::ROUTE_BYPASS_BIT];
      src_vco_d   = route_q[cspm_pkg::ROUTE_SRC_BIT];
      // Calibration edges seen by the VCO band logic
      cal_start_d = cal_ctl_q[cspm_pkg::CAL_BIT] && !act_cal_q;
      cal_reset_d = !cal_ctl_q[cspm_pkg::CAL_BIT] && act_cal_q;
    end
    vco_pwr_d = pll_run_d && src_vco_d;
    ext_pre_d = pll_run_d && !src_vco_d;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      act_cal_q   <= 1'b0;
      pll_pwrdn_q <= 1'b1;
      pll_run_q   <= 1'b0;
      pfd_neg_q   <= 1'b0;
      div_ratio_q <= 3'h4;
      bypass_q    <= 1'b0;
      src_vco_q   <= 1'b0;
      vco_pwr_q   <= 1'b0;
      ext_pre_q   <= 1'b0;
      cal_reset_q <= 1'b0;
      cal_start_q <= 1'b0;
    end else begin
      act_cal_q   <= act_cal_d;
      pll_pwrdn_q <= pll_pwrdn_d;
      pll_run_q   <= pll_run_d;
      pfd_neg_q   <= pfd_neg_d;
      div_ratio_q <= div_ratio_d;
      bypass_q    <= bypass_d;
      src_vco_q   <= src_vco_d;
      vco_pwr_q   <= vco_pwr_d;
      ext_pre_q   <= ext_pre_d;
      cal_reset_q <= cal_reset_d;
      cal_start_q <= cal_start_d;
    end
  end

  assign prdata           = prdata_q;
  assign pready           = pready_q;
  assign pslverr          = pslverr_q;
  assign pll_pwrdn        = pll_pwrdn_q;
  assign pll_run          = pll_run_q;
  assign pfd_negative     = pfd_neg_q;
  assign vco_pwr_en       = vco_pwr_q;
  assign ext_to_prescaler = ext_pre_q;
  assign div_ratio        = div_ratio_q;
  assign div_bypass       = bypass_q;
  assign src_vco          = src_vco_q;
  assign cal_reset        = cal_reset_q;
  assign cal_start        = cal_start_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  reset_default_a: assert property ($past(rst) |-> pll_pwrdn && !pll_run && !src_vco && !div_bypass &&
                                    div_ratio == 3'h4 && !vco_pwr_en)
    else $error("Reset defaults not applied");

  pwrdn_mode_a: assert property (upd_fire && pll_ctl_q[1:0] == 2'h1 |=> pll_pwrdn && !pll_run)
    else $error("Mode 01 did not power down the PLL");

  normal_mode_a: assert property (upd_fire && pll_ctl_q[1:0] == 2'h0 |=> pll_run && !pll_pwrdn)
    else $error("Mode 00 did not run the PLL");

  div_ratio_a: assert property (upd_fire |=> div_ratio == ($past(div_sel_q[2:0]) > 3'h4 ? 3'h6 :
                                 3'($past(div_sel_q[2:0]) + 3'h2)))
    else $error("Divider ratio does not match select code");

  div_range_a: assert property (div_ratio >= 3'h2 && div_ratio <= 3'h6)
    else $error("Divider ratio out of range");

  bypass_route_a: assert property (upd_fire |=> div_bypass == $past(route_q[0]))
    else $error("Bypass bit not applied");

  source_sel_a: assert property (upd_fire |=> src_vco == $past(route_q[1]))
    else $error("Source select not applied");

  pfd_polarity_a: assert property (upd_fire |=> pfd_negative == $past(pll_ctl_q[7]))
    else $error("PFD polarity not applied");

  ext_vco_path_a: assert property (pll_run && !src_vco |-> !vco_pwr_en && ext_to_prescaler)
    else $error("External path left the internal VCO on");

  update_hold_a: assert property (!upd_fire |=> $stable(div_ratio) && $stable(src_vco) &&
                                  $stable(div_bypass) && $stable(pll_run))
    else $error("Active set changed without update");

  cal_start_a: assert property (upd_fire && cal_ctl_q[0] && !act_cal_q |=> cal_start ##1 !cal_start)
    else $error("Calibration start not pulsed once");

  cal_reset_a: assert property (upd_fire && !cal_ctl_q[0] && act_cal_q |=> cal_reset && !cal_start)
    else $error("Calibration reset not pulsed");

  apb_answer_a: assert property (psel && !penable |=> pready)
    else $error("APB answer late");

  pwrdn_vco_off_a: assert property (!pll_run |-> !vco_pwr_en && !ext_to_prescaler)
    else $error("Stopped PLL left a clock path powered");

  update_reads_zero_a: assert property (pready && !pwrite && hit(paddr, cspm_pkg::IDX_UPDATE_STROBE) |->
                                        prdata == 32'h0)
    else $error("Update bit did not read back as zero");

endmodule : cspm_clock_path_cfg

/* testbench/cspm_clock_path_cfg_tb_top.sv */
`timescale 1ns/1ns
module cspm_clock_path_cfg_tb_top;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        core_clk;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pll_pwrdn, pll_run, pfd_negative, vco_pwr_en, ext_to_prescaler;
  logic        div_bypass, src_vco, cal_reset, cal_start;
  logic [2:0]  div_ratio;
  logic [11:0] outs;
  logic [31:0] rdv;
  logic        erv;
  int          failures;
  int          checks_done;

  assign outs = {pll_pwrdn, pll_run, pfd_negative, vco_pwr_en, ext_to_prescaler, div_ratio,
                 div_bypass, src_vco, cal_reset, cal_start};

  cspm_clock_path_cfg uut (
    .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pll_pwrdn(pll_pwrdn), .pll_run(pll_run), .pfd_negative(pfd_negative),
    .vco_pwr_en(vco_pwr_en), .ext_to_prescaler(ext_to_prescaler), .div_ratio(div_ratio),
    .div_bypass(div_bypass), .src_vco(src_vco), .cal_reset(cal_reset), .cal_start(cal_start)
  );

  always #2 core_clk = ~core_clk;

  // ----------------------------------------
  // Bus, compare and expectation helpers
  // ----------------------------------------
  task automatic close_out();
    if (failures == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] d, input logic [3:0] s);
    @(posedge core_clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {idx, 2'b00};
    pwdata  <= d;
    pstrb   <= s;
    @(posedge core_clk);
    penable <= 1'b1;
    // Wait for the answer; only the watchdog ends a hang
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rdv = prdata;
    erv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    pwrite  <= 1'b0;
  endtask : apb

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    apb(1'b1, idx, {24'h0, d}, 4'h1);
  endtask : wr

  task automatic rd_chk(input logic [9:0] idx, input logic [31:0] exp, input logic exp_err);
    apb(1'b0, idx, 32'h0, 4'h0);
    chk(rdv, exp);
    chk({31'h0, erv}, {31'h0, exp_err});
  endtask : rd_chk

  task automatic upd();
    wr(cspm_pkg::IDX_UPDATE_STROBE, 8'h01);
  endtask : upd

  task automatic chk_cfg(input logic [11:0] exp);
    @(negedge core_clk);
    chk({20'h0, outs}, {20'h0, exp});
  endtask : chk_cfg

  function automatic logic [11:0] ex(input logic [1:0] m, input logic p, input logic [2:0] c,
                                     input logic [1:0] r, input logic cr, input logic cs);
    logic run;
    run = (m == 2'h0);
    ex = {m == 2'h1, run, p, run & r[1], run & ~r[1], (c > 3'h4) ? 3'h6 : c + 3'h2, r[0], r[1], cr, cs};
  endfunction : ex

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk_cfg(ex(2'h1, 1'b0, 3'h2, 2'h0, 1'b0, 1'b0));
    rd_chk(cspm_pkg::IDX_PLL_CONTROL, 32'h01, 1'b0);
    rd_chk(cspm_pkg::IDX_VCO_CAL_CONTROL, 32'h00, 1'b0);
    rd_chk(cspm_pkg::IDX_PRESCALE_DIV_SEL, 32'h02, 1'b0);
    rd_chk(cspm_pkg::IDX_INPUT_ROUTING, 32'h00, 1'b0);
    rd_chk(cspm_pkg::IDX_UPDATE_STROBE, 32'h00, 1'b0);
    rd_chk(cspm_pkg::IDX_PATH_STATUS, 32'h0402, 1'b0);
  endtask : t_reset

  task automatic t_mode();
    logic [11:0] prev;
    prev = ex(2'h1, 1'b0, 3'h2, 2'h0, 1'b0, 1'b0);
    for (int i = 0; i < 8; i++) begin
      wr(cspm_pkg::IDX_PLL_CONTROL, {i[2], 5'h0, i[1:0]});
      chk_cfg(prev);
      upd();
      prev = ex(i[1:0], i[2], 3'h2, 2'h0, 1'b0, 1'b0);
      chk_cfg(prev);
      rd_chk(cspm_pkg::IDX_PLL_CONTROL, {24'h0, i[2], 5'h0, i[1:0]}, 1'b0);
    end
  endtask : t_mode

  task automatic t_route();
    wr(cspm_pkg::IDX_PLL_CONTROL, 8'h00);
    for (int r = 0; r < 3; r++) begin
      wr(cspm_pkg::IDX_INPUT_ROUTING, {6'h0, r[1:0]});
      upd();
      chk_cfg(ex(2'h0, 1'b0, 3'h2, r[1:0], 1'b0, 1'b0));
    end
    wr(cspm_pkg::IDX_PLL_CONTROL, 8'h01);
    wr(cspm_pkg::IDX_PRESCALE_DIV_SEL, 8'h00);
    wr(cspm_pkg::IDX_INPUT_ROUTING, 8'h02);
    chk_cfg(ex(2'h0, 1'b0, 3'h2, 2'h2, 1'b0, 1'b0));
    upd();
    chk_cfg(ex(2'h1, 1'b0, 3'h0, 2'h2, 1'b0, 1'b0));
  endtask : t_route

  task automatic t_div();
    wr(cspm_pkg::IDX_PRESCALE_DIV_SEL, 8'h07);
    upd();
    @(negedge core_clk);
    chk({29'h0, div_ratio}, 32'h6);
    for (int c = 4; c >= 0; c--) begin
      wr(cspm_pkg::IDX_PRESCALE_DIV_SEL, {5'h0, c[2:0]});
      upd();
      @(negedge core_clk);
      chk({29'h0, div_ratio}, {29'h0, c[2:0] + 3'h2});
      rd_chk(cspm_pkg::IDX_PRESCALE_DIV_SEL, {29'h0, c[2:0]}, 1'b0);
    end
  endtask : t_div

  task automatic t_cal();
    wr(cspm_pkg::IDX_PLL_CONTROL, 8'h00);
    wr(cspm_pkg::IDX_VCO_CAL_CONTROL, 8'h01);
    upd();
    chk_cfg(ex(2'h0, 1'b0, 3'h0, 2'h2, 1'b0, 1'b1));
    chk_cfg(ex(2'h0, 1'b0, 3'h0, 2'h2, 1'b0, 1'b0));
    wr(cspm_pkg::IDX_VCO_CAL_CONTROL, 8'h00);
    upd();
    chk_cfg(ex(2'h0, 1'b0, 3'h0, 2'h2, 1'b1, 1'b0));
    chk_cfg(ex(2'h0, 1'b0, 3'h0, 2'h2, 1'b0, 1'b0));
    wr(cspm_pkg::IDX_VCO_CAL_CONTROL, 8'h01);
    upd();
    chk_cfg(ex(2'h0, 1'b0, 3'h0, 2'h2, 1'b0, 1'b1));
    upd();
    chk_cfg(ex(2'h0, 1'b0, 3'h0, 2'h2, 1'b0, 1'b0));
  endtask : t_cal

  task automatic t_refuse();
    rd_chk(10'h3ff, 32'h0, 1'b1);
    apb(1'b1, cspm_pkg::IDX_PRESCALE_DIV_SEL, 32'h3, 4'he);
    rd_chk(cspm_pkg::IDX_PRESCALE_DIV_SEL, 32'h0, 1'b0);
    rd_chk(cspm_pkg::IDX_PATH_STATUS, 32'h0235, 1'b0);
  endtask : t_refuse

  initial begin
    core_clk    = 1'b0;
    rst         = 1'b1;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 12'h000;
    pwdata      = 32'h0;
    pstrb       = 4'h0;
    failures    = 0;
    checks_done = 0;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_mode();
    t_route();
    t_cal();
    t_refuse();
    t_div();
    close_out();
  end

  // Hang guard, far beyond the few hundred cycles the run needs
  initial begin
    repeat (5000) @(posedge core_clk);
    failures++;
    close_out();
  end
endmodule : cspm_clock_path_cfg_tb_top
